//--- hw/page_translation_cache.sv
// translation cache store: 2K locations of pointer, permission, tag, valid
// assumes reads are registered: a read issued in one cycle answers the next
`timescale 1ns/1ps
module page_translation_cache (
  input wire logic clk,
  input wire logic arst_n,
  ptc_if.store bus
);
  import walker_pkg::*;

  localparam int ENTRY_W = PPN_W + PERM_W + PTC_TAG_W;

  logic [ENTRY_W-1:0] mem_q [PTC_DEPTH];
  logic [PTC_DEPTH-1:0] valid_q;
  logic [ENTRY_W-1:0] rdata_q;
  logic rvalid_q;
  logic [PTC_TAG_W-1:0] cmp_tag_q;
  wire [PTC_TAG_W-1:0] stored_tag;
  wire tag_equal;

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_idx] <= {bus.wr_tag, bus.wr_perm, bus.wr_ppn}; // [RULE1] [RULE11]
    end
  end

  // valid bits: a fill in the flush cycle survives the flush
  genvar gi;
  generate
    for (gi = 0; gi < PTC_DEPTH; gi++) begin : g_valid
      wire fill_here = bus.wr_en && (bus.wr_idx == PTC_IDX_W'(gi));
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          valid_q[gi] <= 1'b0;
        end else if (fill_here) begin
          valid_q[gi] <= 1'b1; // [RULE15]
        end else if (bus.flush) begin
          valid_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // lookup
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (bus.rd_en) begin
      rdata_q <= mem_q[bus.rd_idx]; // [RULE2]
      cmp_tag_q <= bus.rd_tag;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
    end else if (bus.rd_en) begin
      rvalid_q <= valid_q[bus.rd_idx] && !bus.flush;
    end
  end

  assign stored_tag = rdata_q[ENTRY_W-1 -: PTC_TAG_W];
  assign tag_equal = (stored_tag == cmp_tag_q);
  assign bus.hit = rvalid_q && tag_equal; // [RULE2] [RULE3]
  assign bus.rd_ppn = rdata_q[PPN_W-1:0];
  assign bus.rd_perm = rdata_q[PPN_W +: PERM_W];

endmodule : page_translation_cache

//--- hw/page_translation_walker.sv
// page translation walker: translation cache lookup and three-level table walk
// assumes the memory port is synchronous logic on clk that answers with mem_ack
//
// Operation
// [RULE1] the translation cache holds 2K locations, 8KB, each with pointer, permission, tag, valid; the code keeps 24 bits per location, 6KB.
// [RULE2] low page bits index the cache and a hit needs an equal tag and a set valid bit.
// [RULE3] a location whose valid bit is clear always gives a miss.
// [RULE4] a miss starts a table walk at the onboard group table.
// [RULE5] the segment entry address joins the 14-bit segment pointer and the 10-bit segment index.
// [RULE6] the two lowest address bits are zero on every segment and page entry read.
// [RULE7] the page entry address joins the 20-bit page table pointer and the 4-bit page index.
// [RULE8] the last walk step reads the page entry and takes its 14-bit page pointer.
// [RULE9] a segment entry carries a 20-bit page table pointer and two permission bits.
// [RULE10] the physical address is the page pointer above the unchanged byte offset.
// [RULE11] every valid cache location matches its page entry's pointer and permission bits.
// [RULE12] the physical address is 26 bits: 14-bit page pointer above 12-bit offset.
// [RULE13] the group table has 16 onboard entries of 14-bit segment table pointers.
// [RULE14] a page entry holds a 14-bit page pointer and permission bits.
// [RULE15] a finished walk writes pointer, permission and tag to the cache and sets valid.
// [RULE16] the core access waits until the walk ends and completes with the new address.
`timescale 1ns/1ps
module page_translation_walker (
  input wire logic clk,
  input wire logic arst_n,
  // processor side
  input wire logic cpu_req,
  input wire logic [walker_pkg::VA_W-1:0] cpu_va,
  output logic cpu_ack,
  output logic [walker_pkg::PA_W-1:0] cpu_pa,
  output logic [walker_pkg::PERM_W-1:0] cpu_perm,
  output logic cpu_walked,
  // group table load and readback
  input wire logic gt_we,
  input wire logic [walker_pkg::GRP_W-1:0] gt_idx,
  input wire logic [walker_pkg::STP_W-1:0] gt_wdata,
  output logic [walker_pkg::STP_W-1:0] gt_rdata,
  // cache invalidate
  input wire logic ptc_flush,
  // physical memory read port
  output logic mem_req,
  output logic [walker_pkg::PA_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [walker_pkg::WORD_W-1:0] mem_rdata,
  // status
  output logic busy,
  output logic [walker_pkg::CNT_W-1:0] hit_count,
  output logic [walker_pkg::CNT_W-1:0] miss_count
);
  import walker_pkg::*;

  ptc_if ptc ();

  page_translation_cache u_cache (
    .clk(clk),
    .arst_n(arst_n),
    .bus(ptc.store)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  walk_state_e state_q;
  walk_state_e state_d;
  logic [VA_W-1:0] va_q;
  logic [PTP_W-1:0] ptp_q;
  logic [PA_W-1:0] pa_q;
  logic [PERM_W-1:0] perm_q;
  logic walked_q;
  logic [STP_W-1:0] gt_q [GT_DEPTH];
  logic [CNT_W-1:0] hit_cnt_q;
  logic [CNT_W-1:0] miss_cnt_q;

  // ****************************************************************
  // address fields
  // ****************************************************************
  wire [GRP_W-1:0] va_grp = va_q[GRP_LSB +: GRP_W];
  wire [SEG_W-1:0] va_seg = va_q[SEG_LSB +: SEG_W];
  wire [PIDX_W-1:0] va_pidx = va_q[PIDX_LSB +: PIDX_W];
  wire [OFS_W-1:0] va_ofs = va_q[OFS_LSB +: OFS_W];
  wire [PTC_IDX_W-1:0] va_idx = va_q[PTC_IDX_LSB +: PTC_IDX_W];
  wire [PTC_TAG_W-1:0] va_tag = va_q[PTC_TAG_LSB +: PTC_TAG_W];

  wire [STP_W-1:0] seg_base = gt_q[va_grp]; // [RULE4] [RULE13]
  wire [PA_W-1:0] seg_addr = {seg_base, va_seg, ENTRY_ALIGN}; // [RULE5] [RULE6]
  wire [PA_W-1:0] page_addr = {ptp_q, va_pidx, ENTRY_ALIGN}; // [RULE7] [RULE6]

  wire [PTP_W-1:0] se_ptp = mem_rdata[SE_PTP_LSB +: PTP_W]; // [RULE9]
  wire [PERM_W-1:0] se_perm = mem_rdata[SE_PERM_LSB +: PERM_W];
  wire [PPN_W-1:0] pe_ppn = mem_rdata[PE_PPN_LSB +: PPN_W]; // [RULE8] [RULE14]
  wire [PERM_W-1:0] pe_perm = mem_rdata[PE_PERM_LSB +: PERM_W];

  wire in_idle = (state_q == ST_IDLE);
  wire in_cmp = (state_q == ST_CMP);
  wire in_seg = (state_q == ST_SEG);
  wire in_page = (state_q == ST_PAGE);
  wire take_req = in_idle && cpu_req;
  wire cmp_hit = in_cmp && ptc.hit;
  wire cmp_miss = in_cmp && !ptc.hit;
  wire seg_done = in_seg && mem_ack;
  wire page_done = in_page && mem_ack;

  // ****************************************************************
  // cache connections
  // ****************************************************************
  assign ptc.rd_en = (state_q == ST_LOOK);
  assign ptc.rd_idx = va_idx; // [RULE2]
  assign ptc.rd_tag = va_tag;
  assign ptc.wr_en = page_done; // [RULE15]
  assign ptc.wr_idx = va_idx;
  assign ptc.wr_tag = va_tag;
  assign ptc.wr_ppn = pe_ppn; // [RULE11]
  assign ptc.wr_perm = pe_perm; // [RULE11]
  assign ptc.flush = ptc_flush;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cpu_req) begin
          state_d = ST_LOOK;
        end
      end
      ST_LOOK: begin
        state_d = ST_CMP;
      end
      ST_CMP: begin
        state_d = ptc.hit ? ST_RESP : ST_SEG; // [RULE3] [RULE4]
      end
      ST_SEG: begin
        if (mem_ack) begin
          state_d = ST_PAGE;
        end
      end
      ST_PAGE: begin
        if (mem_ack) begin
          state_d = ST_RESP;
        end
      end
      ST_RESP: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // request capture and walk registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      va_q <= '0;
    end else if (take_req) begin
      va_q <= cpu_va;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptp_q <= '0;
    end else if (seg_done) begin
      ptp_q <= se_ptp; // [RULE9]
    end
  end

  // the translated address and permission come from the cache on a hit,
  // from the page entry after a walk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_q <= '0;
      perm_q <= '0;
      walked_q <= 1'b0;
    end else if (cmp_hit) begin
      pa_q <= {ptc.rd_ppn, va_ofs}; // [RULE10] [RULE12]
      perm_q <= ptc.rd_perm;
      walked_q <= 1'b0;
    end else if (page_done) begin
      pa_q <= {pe_ppn, va_ofs}; // [RULE8] [RULE10] [RULE12]
      perm_q <= pe_perm;
      walked_q <= 1'b1;
    end
  end

  // ****************************************************************
  // group table
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < GT_DEPTH; gi++) begin : g_group
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          gt_q[gi] <= GT_RESET;
        end else if (gt_we && (gt_idx == GRP_W'(gi))) begin
          gt_q[gi] <= gt_wdata; // [RULE13]
        end
      end
    end
  endgenerate

  assign gt_rdata = gt_q[gt_idx];

  // ****************************************************************
  // statistics
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hit_cnt_q <= '0;
      miss_cnt_q <= '0;
    end else begin
      if (cmp_hit) begin
        hit_cnt_q <= hit_cnt_q + CNT_W'(1);
      end
      if (cmp_miss) begin
        miss_cnt_q <= miss_cnt_q + CNT_W'(1);
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // during a walk seg_base changes only with gt writes; loading the table mid walk is the
  // user's hazard, the address is taken live while mem_req stands
  assign mem_req = in_seg || in_page;
  assign mem_addr = in_page ? page_addr : (in_seg ? seg_addr : '0);
  assign cpu_ack = (state_q == ST_RESP); // [RULE16]
  assign cpu_pa = pa_q;
  assign cpu_perm = perm_q;
  assign cpu_walked = walked_q;
  assign busy = !in_idle;
  assign hit_count = hit_cnt_q;
  assign miss_count = miss_cnt_q;

endmodule : page_translation_walker

//--- hw/ptc_if.sv
// carrier between the walker and its translation cache store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ptc_if;
  import walker_pkg::*;
  logic rd_en;
  logic [PTC_IDX_W-1:0] rd_idx;
  logic [PTC_TAG_W-1:0] rd_tag;
  logic hit;
  logic [PPN_W-1:0] rd_ppn;
  logic [PERM_W-1:0] rd_perm;
  logic wr_en;
  logic [PTC_IDX_W-1:0] wr_idx;
  logic [PTC_TAG_W-1:0] wr_tag;
  logic [PPN_W-1:0] wr_ppn;
  logic [PERM_W-1:0] wr_perm;
  logic flush;
  modport walker (output rd_en, rd_idx, rd_tag, wr_en, wr_idx, wr_tag, wr_ppn, wr_perm,
                  flush, input hit, rd_ppn, rd_perm);
  modport store (input rd_en, rd_idx, rd_tag, wr_en, wr_idx, wr_tag, wr_ppn, wr_perm,
                 flush, output hit, rd_ppn, rd_perm);
endinterface : ptc_if

//--- hw/walker_pkg.sv
// constants shared by the page translation walker and its translation cache
// assumes one system clock; all widths are fixed at the documented values
package walker_pkg;

  // ****************************************************************
  // address layout
  // ****************************************************************
  localparam int VA_W = 30;
  localparam int PA_W = 26;
  localparam int OFS_W = 12;
  localparam int PPN_W = 14;
  localparam int PERM_W = 2;
  localparam int GRP_W = 4;
  localparam int SEG_W = 10;
  localparam int PIDX_W = 4;
  localparam int STP_W = 14;
  localparam int PTP_W = 20;
  localparam int WORD_W = 32;

  localparam int OFS_LSB = 0;
  localparam int PIDX_LSB = 12;
  localparam int SEG_LSB = 16;
  localparam int GRP_LSB = 26;

  // ****************************************************************
  // translation cache geometry
  // ****************************************************************
  localparam int PTC_DEPTH = 2048;
  localparam int PTC_IDX_W = 11;
  localparam int PTC_IDX_LSB = 12;
  localparam int PTC_TAG_W = 7;
  localparam int PTC_TAG_LSB = 23;
  localparam int GT_DEPTH = 16;

  // ****************************************************************
  // table entry fields
  // ****************************************************************
  localparam int SE_PTP_LSB = 0;
  localparam int SE_PERM_LSB = 20;
  localparam int PE_PPN_LSB = 0;
  localparam int PE_PERM_LSB = 14;
  localparam logic [1:0] ENTRY_ALIGN = 2'h0;
  localparam logic [STP_W-1:0] GT_RESET = 14'h0000;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOK, ST_CMP, ST_SEG, ST_PAGE, ST_RESP
  } walk_state_e;

endpackage : walker_pkg

//--- tb/page_translation_walker_tb.sv
// self-checking bench for the page translation walker
// assumes walker_mem_model answers reads and walker_monitor is bound
`timescale 1ns/1ps
module page_translation_walker_tb;
  import walker_pkg::*;
  logic clk, arst_n, cpu_req, gt_we, ptc_flush, mem_req, mem_ack, cpu_ack, cpu_walked, busy;
  logic [VA_W-1:0] cpu_va;
  logic [PA_W-1:0] cpu_pa, mem_addr;
  logic [PERM_W-1:0] cpu_perm;
  logic [GRP_W-1:0] gt_idx;
  logic [STP_W-1:0] gt_wdata, gt_rdata;
  logic [WORD_W-1:0] mem_rdata;
  logic [CNT_W-1:0] hit_count, miss_count;
  logic [STP_W-1:0] gt_m [GT_DEPTH];
  logic [PTC_TAG_W+PERM_W+PPN_W-1:0] ptc_m [int];
  logic [PA_W+PERM_W:0] exp_q [$];
  int failures, n_checks, hits, misses;
  page_translation_walker dut (.clk(clk), .arst_n(arst_n), .cpu_req(cpu_req),
    .cpu_va(cpu_va), .cpu_ack(cpu_ack), .cpu_pa(cpu_pa), .cpu_perm(cpu_perm),
    .cpu_walked(cpu_walked), .gt_we(gt_we), .gt_idx(gt_idx), .gt_wdata(gt_wdata),
    .gt_rdata(gt_rdata), .ptc_flush(ptc_flush), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .hit_count(hit_count),
    .miss_count(miss_count));
  walker_mem_model mem (.clk(clk), .arst_n(arst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // notes the expected translation, then holds the request until the answer
  task automatic lookup(input logic [VA_W-1:0] va);
    int idx;
    int n;
    logic [PA_W-1:0] pa;
    logic [WORD_W-1:0] w;
    logic walked;
    idx = int'(va[22:12]);
    pa = {gt_m[va[29:26]], va[25:16], 2'h0};
    w = mem.word(pa);
    pa = {w[19:0], va[15:12], 2'h0};
    w = mem.word(pa);
    walked = !(ptc_m.exists(idx) && ptc_m[idx][22:16] == va[29:23]);
    if (walked)
      ptc_m[idx] = {va[29:23], w[15:0]};
    if (walked)
      misses++;
    else
      hits++;
    exp_q.push_back({ptc_m[idx][13:0], va[11:0], ptc_m[idx][15:14], walked});
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_va <= va;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      stop_test();
    end
    @(posedge clk);
    cpu_req <= 1'b0;
    cpu_va <= ~va;
  endtask : lookup
  always @(negedge clk) begin
    if (cpu_ack === 1'b1)
      check("translation", 32'({cpu_pa, cpu_perm, cpu_walked}), 32'(exp_q.pop_front()));
  end
  initial begin
    logic [VA_W-1:0] pool [8];
    logic [STP_W-1:0] v;
    {cpu_req, gt_we, ptc_flush, arst_n} = 4'h0;
    cpu_va = 30'h0;
    gt_idx = 4'h0;
    gt_wdata = 14'h0;
    {failures, n_checks, hits, misses} = 128'h0;
    void'($urandom(91));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("reset", {mem_req, cpu_ack, hit_count, gt_rdata}, 32'h0);
    for (int i = 0; i < GT_DEPTH; i++) begin
      v = 14'($urandom);
      gt_m[i] = v;
      @(posedge clk);
      gt_we <= 1'b1;
      gt_idx <= 4'(i);
      gt_wdata <= v;
    end
    @(posedge clk);
    gt_we <= 1'b0;
    for (int i = 0; i < GT_DEPTH; i++) begin
      @(posedge clk);
      gt_idx <= 4'(i);
      @(negedge clk);
      check("group_table", 32'(gt_rdata), 32'(gt_m[i]));
    end
    for (int i = 0; i < 8; i++)
      pool[i] = 30'($urandom);
    pool[1] = pool[0] ^ 30'h00800000;
    for (int i = 0; i < 48; i++)
      lookup(pool[$urandom_range(7)] ^ 30'($urandom_range(4095)));
    @(posedge clk);
    ptc_flush <= 1'b1;
    @(posedge clk);
    ptc_flush <= 1'b0;
    ptc_m.delete();
    lookup(pool[0]);
    lookup(pool[0]);
    @(negedge clk);
    check("hits", 32'(hit_count), 32'(hits));
    check("misses", 32'(miss_count), 32'(misses));
    stop_test();
  end
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule : page_translation_walker_tb

//--- tb/walker_mem_model.sv
// physical memory holding the segment and page tables
// assumes one read at a time, answered after a random wait
`timescale 1ns/1ps
module walker_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mem_req,
  input wire logic [walker_pkg::PA_W-1:0] mem_addr,
  output logic mem_ack,
  output logic [walker_pkg::WORD_W-1:0] mem_rdata
);
  import walker_pkg::*;
  logic [1:0] wait_q;
  // segment entry: pointer [19:0], perm [21:20]; page entry: ppn [13:0], perm [15:14]
  function automatic logic [WORD_W-1:0] word(input logic [PA_W-1:0] a);
    return {a[9:2] ^ 8'ha5, a[25:2]};
  endfunction : word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q <= 2'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= 2'($urandom_range(3));
    end else if (mem_req && wait_q == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= word(mem_addr);
    end else if (mem_req) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule : walker_mem_model

//--- tb/walker_monitor.sv
// port checker for the page translation walker
// assumes cpu_va is held by the core while busy is high
`timescale 1ns/1ps
module walker_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cpu_req,
  input wire logic [walker_pkg::VA_W-1:0] cpu_va,
  input wire logic cpu_ack,
  input wire logic [walker_pkg::PA_W-1:0] cpu_pa,
  input wire logic cpu_walked,
  input wire logic mem_req,
  input wire logic [walker_pkg::PA_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [walker_pkg::WORD_W-1:0] mem_rdata,
  input wire logic busy,
  input wire logic [walker_pkg::CNT_W-1:0] hit_count
);
  import walker_pkg::*;
  logic page_q;
  wire take = cpu_req && !busy;
  wire [PTP_W-1:0] seg_ptp = mem_rdata[PTP_W-1:0];
  wire [PPN_W-1:0] pg_ppn = mem_rdata[PPN_W-1:0];
  // marks the second read of a walk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      page_q <= 1'b0;
    else if (!busy)
      page_q <= 1'b0;
    else if (mem_req && mem_ack)
      page_q <= !page_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence seg_done;
    mem_req && mem_ack && !page_q;
  endsequence
  sequence page_done;
    mem_req && mem_ack && page_q;
  endsequence
  chk_entry_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("entry read not word aligned");
  chk_seg_index: assert property (mem_req && !page_q |-> mem_addr[11:2] == cpu_va[25:16])
    else $error("segment read index wrong");
  chk_walk_start: assert property ($rose(mem_req) |-> $past(take, 3) && !page_q)
    else $error("walk did not start three cycles after take");
  chk_page_addr: assert property (seg_done |=> mem_req &&
    mem_addr == {$past(seg_ptp), cpu_va[15:12], 2'h0}) else $error("page read address wrong");
  chk_walk_result: assert property (page_done |=> cpu_ack && cpu_walked &&
    cpu_pa == {$past(pg_ppn), cpu_va[11:0]}) else $error("walk result wrong");
  chk_offset_pass: assert property (cpu_ack |-> cpu_pa[11:0] == cpu_va[11:0])
    else $error("byte offset changed");
  chk_hit_time: assert property (cpu_ack && !cpu_walked |-> $past(take, 3) &&
    hit_count == $past(hit_count) + 16'h1) else $error("hit answer late or uncounted");
  chk_ack_single: assert property (cpu_ack |=> !cpu_ack && !busy)
    else $error("answer longer than one cycle");
  chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before answer");
endmodule : walker_monitor

bind page_translation_walker walker_monitor mon (.clk(clk), .arst_n(arst_n),
  .cpu_req(cpu_req), .cpu_va(cpu_va), .cpu_ack(cpu_ack), .cpu_pa(cpu_pa),
  .cpu_walked(cpu_walked), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .busy(busy), .hit_count(hit_count));
